// *** common/hdbb_pkg.sv ***
// Package: constants and types for the host data bus buffer port
package hdbb_pkg;
    localparam int NUM_CH = 2;
    localparam int FIFO_DEPTH = 4;

    // Core-side register offsets
    localparam logic [7:0] ADDR_DATA_CH0 = 8'h48;
    localparam logic [7:0] ADDR_STAT_CH0 = 8'h49;
    localparam logic [7:0] ADDR_CTRL_CH0 = 8'h4a;
    localparam logic [7:0] ADDR_DATA_CH1 = 8'h4c;
    localparam logic [7:0] ADDR_STAT_CH1 = 8'h4d;
    localparam logic [7:0] ADDR_CTRL_CH1 = 8'h4e;

    // Reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // Status field positions
    localparam int STAT_OBF_BIT = 0;
    localparam int STAT_IBF_BIT = 1;
    localparam int STAT_A0_BIT  = 3;
    // Bits the core may write in the status register (2, 4..7)
    localparam logic [7:0] STAT_USER_MASK = 8'hf4;

    // Control field positions
    localparam int CTRL_SLAVE_BIT  = 7; // Control 0
    localparam int CTRL_DOUBLE_BIT = 7; // Control 1
    localparam int CTRL_RW_TYPE_BIT = 6; // Control 0: 1 = R/W with enable

    typedef struct packed {
        logic       ch;
        logic       a0;
        logic [7:0] data;
    } hdbb_hwr_t;

    localparam int HWR_W = $bits(hdbb_hwr_t);
endpackage : hdbb_pkg

// *** design/hdbb_top.sv ***
// Host data bus buffer port: write FIFO and two-channel slave port
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Control 0 bit 7 enables slave port
// - Control 1 bit 7 selects double channel
// - Supports R/W-enable or separate strobes
// - Master write raises input-full request
// - Master data read (A0 low) raises output-empty request
// - One request pair per channel
// - Data pins tri-state bidirectional bus
// - Strobes, selects, A0 are master inputs
// - Status bits 0,1,3 hardware only
// - Status bits 2,4-7 core read/write
// - Bit0 output full, bit1 input full
// - Master read, A0 high returns status
// - Output flag: core sets, master clears
// - Input flag: master sets, core clears
// - A0 latched into status bit 3
// - Master write latched, core reads data
// - Core write loads output buffer
// - Core or DMA services the buffers

module hdbb_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap by compare so a depth that is not a power of two works
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                                                       : wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                                                       : rd_ptr_reg + 1'b1;
        end
    end

    // One extra bit tells full from empty
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // hdbb_fifo

module hdbb_top #(
    parameter int FIFO_DEPTH_P = hdbb_pkg::FIFO_DEPTH
) (
    input  wire logic                       CLOCK_IN,
    input  wire logic                       ARST_N_IN,
    // Core register port
    input  wire logic [7:0]                 CORE_ADDR_IN,
    input  wire logic                       CORE_WR_IN,
    input  wire logic                       CORE_RD_IN,
    input  wire logic [7:0]                 CORE_WDATA_IN,
    output logic      [7:0]                 CORE_RDATA_OUT,
    output logic      [hdbb_pkg::NUM_CH-1:0] IRQ_IN_FULL_OUT,
    output logic      [hdbb_pkg::NUM_CH-1:0] IRQ_OUT_EMPTY_OUT,
    // Master pins
    input  wire logic [7:0]                 HOST_DATA_PINS_IN,
    output logic      [7:0]                 HOST_DATA_PINS_OUT,
    output logic                            HOST_DATA_PINS_OE_OUT,
    input  wire logic                       RD_N_OR_E_IN,
    input  wire logic                       WR_N_OR_RW_IN,
    input  wire logic                       HOST_SELECT_CH0_N_IN,
    input  wire logic                       SHARED_SELECT_PIN_N_IN,
    input  wire logic                       CMD_DATA_SELECT_IN,
    output logic      [hdbb_pkg::NUM_CH-1:0] OUT_FULL_FLAG_OUT,
    output logic      [hdbb_pkg::NUM_CH-1:0] IN_FULL_FLAG_N_OUT,
    output logic                            HOST_WR_READY_OUT
);
    import hdbb_pkg::*;

    // Register views per channel
    logic [7:0]      ctrl_reg [NUM_CH];
    logic [7:0]      status   [NUM_CH];
    logic [7:0]      in_buf   [NUM_CH];
    logic [7:0]      out_buf  [NUM_CH];

    // Mode decode
    logic            slave_en;
    logic            double_mode;
    logic            rw_type;

    // Master strobes and selects
    logic            rd_act;
    logic            wr_act;
    logic            sel_any;
    logic            sel_ch;
    logic            rd_act_reg;
    logic            wr_act_reg;
    logic            rd_ch_reg;
    logic            rd_a0_reg;

    // Access edges
    logic            wr_start;
    logic            rd_end;

    // Write queue
    hdbb_hwr_t       fifo_in;
    hdbb_hwr_t       fifo_out;
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic            fifo_out_ready;

    // Per-channel events
    logic [NUM_CH-1:0] ibf;
    logic [NUM_CH-1:0] land;
    logic [NUM_CH-1:0] host_rd_obuf;
    logic [7:0]      rdata_next;

    assign slave_en    = ctrl_reg[0][CTRL_SLAVE_BIT];
    assign double_mode = ctrl_reg[1][CTRL_DOUBLE_BIT];
    assign rw_type     = ctrl_reg[0][CTRL_RW_TYPE_BIT];

    // Strobe decode for both master styles; pins are plain inputs
    always_comb begin
        if (rw_type) begin
            rd_act = RD_N_OR_E_IN & WR_N_OR_RW_IN;
            wr_act = RD_N_OR_E_IN & ~WR_N_OR_RW_IN;
        end else begin
            rd_act = ~RD_N_OR_E_IN;
            wr_act = ~WR_N_OR_RW_IN;
        end
    end

    // Shared pin only selects channel 1 in double mode; channel 0 wins ties
    assign sel_ch  = HOST_SELECT_CH0_N_IN;
    assign sel_any = slave_en & (~HOST_SELECT_CH0_N_IN |
                     (double_mode & ~SHARED_SELECT_PIN_N_IN));

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rd_act_reg <= 1'b0;
            wr_act_reg <= 1'b0;
            rd_ch_reg  <= 1'b0;
            rd_a0_reg  <= 1'b0;
        end else begin
            rd_act_reg <= rd_act & sel_any;
            wr_act_reg <= wr_act & sel_any;
            if (rd_act & sel_any & ~rd_act_reg) begin
                rd_ch_reg <= sel_ch;
                rd_a0_reg <= CMD_DATA_SELECT_IN;
            end
        end
    end

    assign wr_start = wr_act & sel_any & ~wr_act_reg;
    assign rd_end   = rd_act_reg & ~(rd_act & sel_any);

    // Writes are queued so a fast master does not overrun a busy buffer
    assign fifo_in.ch   = sel_ch;
    assign fifo_in.a0   = CMD_DATA_SELECT_IN;
    assign fifo_in.data = HOST_DATA_PINS_IN;
    // Head blocks while its buffer is full, so byte order is kept
    assign fifo_out_ready = ~ibf[fifo_out.ch];

    hdbb_fifo #(
        .WIDTH (HWR_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .clk       (CLOCK_IN),
        .arst_n    (ARST_N_IN),
        .in_valid  (wr_start),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [7:0] ctrl_q;
        logic [7:0] user_q;
        logic [7:0] in_q;
        logic [7:0] out_q;
        logic       obf_q;
        logic       ibf_q;
        logic       a0_q;
        logic       core_wr_data;
        logic       core_rd_data;

        assign core_wr_data = CORE_WR_IN &
            (CORE_ADDR_IN == (c == 0 ? ADDR_DATA_CH0 : ADDR_DATA_CH1));
        assign core_rd_data = CORE_RD_IN &
            (CORE_ADDR_IN == (c == 0 ? ADDR_DATA_CH0 : ADDR_DATA_CH1));
        assign land[c] = fifo_out_valid & fifo_out_ready & (fifo_out.ch == 1'(c));
        assign host_rd_obuf[c] = rd_end & (rd_ch_reg == 1'(c)) & ~rd_a0_reg;

        always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                ctrl_q <= RST_CTRL;
                user_q <= RST_STAT;
            end else begin
                if (CORE_WR_IN &
                    CORE_ADDR_IN == (c == 0 ? ADDR_CTRL_CH0 : ADDR_CTRL_CH1)) begin
                    ctrl_q <= CORE_WDATA_IN;
                end
                if (CORE_WR_IN &
                    CORE_ADDR_IN == (c == 0 ? ADDR_STAT_CH0 : ADDR_STAT_CH1)) begin
                    user_q <= CORE_WDATA_IN & STAT_USER_MASK;
                end
            end
        end

        // Input byte and its A0 level stay until the next landing
        always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                in_q <= RST_DATA;
                a0_q <= 1'b0;
            end else if (land[c]) begin
                in_q <= fifo_out.data;
                a0_q <= fifo_out.a0;
            end
        end

        // Input flag; a landing byte beats a same-cycle core read
        always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                ibf_q <= 1'b0;
            end else if (land[c]) begin
                ibf_q <= 1'b1;
            end else if (core_rd_data) begin
                ibf_q <= 1'b0;
            end
        end

        always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                out_q <= RST_DATA;
            end else if (core_wr_data) begin
                out_q <= CORE_WDATA_IN;
            end
        end

        // Output flag; core write wins over a same-cycle master read
        always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                obf_q <= 1'b0;
            end else if (core_wr_data) begin
                obf_q <= 1'b1;
            end else if (host_rd_obuf[c]) begin
                obf_q <= 1'b0;
            end
        end

        always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                IRQ_IN_FULL_OUT[c]   <= 1'b0;
                IRQ_OUT_EMPTY_OUT[c] <= 1'b0;
            end else begin
                IRQ_IN_FULL_OUT[c]   <= land[c];
                IRQ_OUT_EMPTY_OUT[c] <= host_rd_obuf[c];
            end
        end

        // Flag pins lag the flags by one clock; the request comes first
        always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                OUT_FULL_FLAG_OUT[c]  <= 1'b0;
                IN_FULL_FLAG_N_OUT[c] <= 1'b1;
            end else begin
                OUT_FULL_FLAG_OUT[c]  <= obf_q;
                IN_FULL_FLAG_N_OUT[c] <= ~ibf_q;
            end
        end

        assign ctrl_reg[c] = ctrl_q;
        assign in_buf[c]   = in_q;
        assign out_buf[c]  = out_q;
        assign ibf[c]      = ibf_q;
        always_comb begin
            status[c] = user_q;
            status[c][STAT_OBF_BIT] = obf_q;
            status[c][STAT_IBF_BIT] = ibf_q;
            status[c][STAT_A0_BIT]  = a0_q;
        end
    end

    // Core read mux; unmapped addresses read zero
    always_comb begin
        unique case (CORE_ADDR_IN)
            ADDR_DATA_CH0: rdata_next = in_buf[0];
            ADDR_STAT_CH0: rdata_next = status[0];
            ADDR_CTRL_CH0: rdata_next = ctrl_reg[0];
            ADDR_DATA_CH1: rdata_next = in_buf[1];
            ADDR_STAT_CH1: rdata_next = status[1];
            ADDR_CTRL_CH1: rdata_next = ctrl_reg[1];
            default:       rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            CORE_RDATA_OUT <= 8'h00;
        end else begin
            CORE_RDATA_OUT <= CORE_RD_IN ? rdata_next : 8'h00;
        end
    end

    // Ready is one clock late; a master must leave room for that
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            HOST_WR_READY_OUT <= 1'b0;
        end else begin
            HOST_WR_READY_OUT <= fifo_in_ready;
        end
    end

    // Pin drive lags the strobe by two clocks (via rd_act_reg); output is registered
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            HOST_DATA_PINS_OE_OUT <= 1'b0;
        end else begin
            HOST_DATA_PINS_OE_OUT <= rd_act_reg & rd_act & sel_any;
        end
    end

    // Channel and A0 were latched at the start of the read
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            HOST_DATA_PINS_OUT <= 8'h00;
        end else begin
            HOST_DATA_PINS_OUT <= rd_a0_reg ? status[rd_ch_reg]
                                            : out_buf[rd_ch_reg];
        end
    end
endmodule // hdbb_top

`default_nettype wire

// *** test/hdbb_top_checker.sv ***
// Checker: port-level properties of the host data bus buffer
`timescale 1ns/1ps
`default_nettype none
module hdbb_top_checker import hdbb_pkg::*; #(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input wire logic       CLOCK_IN,
    input wire logic       ARST_N_IN,
    input wire logic [7:0] CORE_ADDR_IN,
    input wire logic       CORE_WR_IN,
    input wire logic       CORE_RD_IN,
    input wire logic [1:0] IRQ_IN_FULL_OUT,
    input wire logic [1:0] IRQ_OUT_EMPTY_OUT,
    input wire logic       HOST_DATA_PINS_OE_OUT,
    input wire logic       HOST_SELECT_CH0_N_IN,
    input wire logic       SHARED_SELECT_PIN_N_IN,
    input wire logic [1:0] OUT_FULL_FLAG_OUT,
    input wire logic [1:0] IN_FULL_FLAG_N_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!ARST_N_IN);
    property p_oe_idle;
        $past(HOST_SELECT_CH0_N_IN && SHARED_SELECT_PIN_N_IN)
            |-> !HOST_DATA_PINS_OE_OUT;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("pins driven with no select");
    property p_oe_rise;
        $rose(HOST_DATA_PINS_OE_OUT)
            |-> $past(!HOST_SELECT_CH0_N_IN || !SHARED_SELECT_PIN_N_IN);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("pins driven without a select");
    property p_in_irq0;
        IRQ_IN_FULL_OUT[0]
            |-> ##1 (!IN_FULL_FLAG_N_OUT[0] && !IRQ_IN_FULL_OUT[0]);
    endproperty
    a_in_irq0: assert property (p_in_irq0)
        else $error("input request 0 without full flag");
    property p_in_irq1;
        IRQ_IN_FULL_OUT[1] |-> ##1 !IN_FULL_FLAG_N_OUT[1];
    endproperty
    a_in_irq1: assert property (p_in_irq1)
        else $error("input request 1 without full flag");
    property p_out_irq0;
        IRQ_OUT_EMPTY_OUT[0]
            |-> ##1 (!OUT_FULL_FLAG_OUT[0] && !IRQ_OUT_EMPTY_OUT[0]);
    endproperty
    a_out_irq0: assert property (p_out_irq0)
        else $error("output request 0 while still full");
    property p_out_irq1;
        IRQ_OUT_EMPTY_OUT[1] |-> ##1 !OUT_FULL_FLAG_OUT[1];
    endproperty
    a_out_irq1: assert property (p_out_irq1)
        else $error("output request 1 while still full");
    property p_obf_set;
        CORE_WR_IN && CORE_ADDR_IN == ADDR_DATA_CH0
            |-> ##[1:2] OUT_FULL_FLAG_OUT[0];
    endproperty
    a_obf_set: assert property (p_obf_set)
        else $error("output flag not set by core write");
    property p_ibf_clr;
        CORE_RD_IN && CORE_ADDR_IN == ADDR_DATA_CH0 && !IN_FULL_FLAG_N_OUT[0]
            |-> ##[1:2] IN_FULL_FLAG_N_OUT[0];
    endproperty
    a_ibf_clr: assert property (p_ibf_clr)
        else $error("input flag not cleared by core read");
endmodule // hdbb_top_checker
bind hdbb_top hdbb_top_checker #(.FIFO_DEPTH_P(FIFO_DEPTH_P))
    hdbb_top_checker_inst (.CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN),
    .CORE_ADDR_IN(CORE_ADDR_IN), .CORE_WR_IN(CORE_WR_IN),
    .CORE_RD_IN(CORE_RD_IN), .IRQ_IN_FULL_OUT(IRQ_IN_FULL_OUT),
    .IRQ_OUT_EMPTY_OUT(IRQ_OUT_EMPTY_OUT),
    .HOST_DATA_PINS_OE_OUT(HOST_DATA_PINS_OE_OUT),
    .HOST_SELECT_CH0_N_IN(HOST_SELECT_CH0_N_IN),
    .SHARED_SELECT_PIN_N_IN(SHARED_SELECT_PIN_N_IN),
    .OUT_FULL_FLAG_OUT(OUT_FULL_FLAG_OUT),
    .IN_FULL_FLAG_N_OUT(IN_FULL_FLAG_N_OUT));
`default_nettype wire

// *** test/hdbb_host_model.sv ***
// Host model: master processor driving the parallel port pins
`timescale 1ns/1ps
`default_nettype none
module hdbb_host_model (
    input  wire logic       clk,
    input  wire logic       rw_mode,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_oe,
    output logic      [7:0] pins,
    output logic            rd_n_or_e,
    output logic            wr_n_or_rw,
    output logic            sel0_n,
    output logic            sel1_n,
    output logic            a0
);
    logic [7:0] drv;
    logic       drv_en;
    // Released bus shows the inverse level, so a stale byte never passes
    always_comb pins = dev_oe ? dev_data : (drv_en ? drv : ~drv);
    task idle();
        drv_en = 1'b0;
        rd_n_or_e = !rw_mode;
        wr_n_or_rw = 1'b1;
        sel0_n = 1'b1;
        sel1_n = 1'b1;
    endtask
    initial begin
        a0 = 1'b0;
        drv = 8'h00;
        idle();
    end
    // Select and A0 held steady until the strobe is released
    task xfer(input logic ch, input logic rd, input logic cmd,
              input logic [7:0] d, output logic [7:0] q);
        a0 = cmd;
        drv = d;
        drv_en = !rd;
        if (ch) sel1_n = 1'b0;
        else sel0_n = 1'b0;
        if (rw_mode) begin
            wr_n_or_rw = rd;
            rd_n_or_e = 1'b1;
        end else if (rd) begin
            rd_n_or_e = 1'b0;
        end else begin
            wr_n_or_rw = 1'b0;
        end
        repeat (rd ? 3 : 1) @(posedge clk);
        q = pins;
        #1 idle();
        // Two quiet edges: the device lets go of the pins one cycle late
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule // hdbb_host_model
`default_nettype wire

// *** test/host_data_bus_buffer_test.sv ***
// Testbench: register, master-port and buffer scenarios for the host port
`timescale 1ns/1ps
`default_nettype none
module host_data_bus_buffer_test;
    import hdbb_pkg::*;
    logic       clk, rst_n, wr, rd, rw_mode, oe, ready, e_n, w_n, s0_n, s1_n;
    logic       a0;
    logic [7:0] addr, wdata, rdata, pin_in, pin_out, q;
    logic [1:0] irq_in, irq_out, obf, ibf_n;
    int         n_errors, samples_checked, n_in[2], n_out[2];
    hdbb_top hdbb_top_inst (.CLOCK_IN(clk), .ARST_N_IN(rst_n),
        .CORE_ADDR_IN(addr), .CORE_WR_IN(wr), .CORE_RD_IN(rd),
        .CORE_WDATA_IN(wdata), .CORE_RDATA_OUT(rdata),
        .IRQ_IN_FULL_OUT(irq_in), .IRQ_OUT_EMPTY_OUT(irq_out),
        .HOST_DATA_PINS_IN(pin_in), .HOST_DATA_PINS_OUT(pin_out),
        .HOST_DATA_PINS_OE_OUT(oe), .RD_N_OR_E_IN(e_n), .WR_N_OR_RW_IN(w_n),
        .HOST_SELECT_CH0_N_IN(s0_n), .SHARED_SELECT_PIN_N_IN(s1_n),
        .CMD_DATA_SELECT_IN(a0), .OUT_FULL_FLAG_OUT(obf),
        .IN_FULL_FLAG_N_OUT(ibf_n), .HOST_WR_READY_OUT(ready));
    hdbb_host_model hdbb_host_model_inst (.clk(clk), .rw_mode(rw_mode),
        .dev_data(pin_out), .dev_oe(oe), .pins(pin_in), .rd_n_or_e(e_n),
        .wr_n_or_rw(w_n), .sel0_n(s0_n), .sel1_n(s1_n), .a0(a0));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            n_in[c] += int'(irq_in[c] === 1'b1);
            n_out[c] += int'(irq_out[c] === 1'b1);
        end
    end
    task summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every core access waits an edge first so strobes never toggle twice
    task cw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask
    task rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1 rd = 1'b0;
        chk(rdata, exp);
    endtask
    // Bounded wait for a request count; k selects input or output requests
    task wt(input int k, input int c, input int e);
        for (int i = 0; i < 60; i++) begin
            if ((k ? n_out[c] : n_in[c]) >= e) return;
            @(posedge clk);
            #1;
        end
        chk(8'hee, 8'h00);
        summarize();
    endtask
    task t_regs();
        for (int a = 'h48; a < 'h4f; a++) rc(8'(a), 8'h00);
        chk({6'h0, ibf_n}, 8'h03);
        cw(ADDR_STAT_CH0, 8'hff);
        rc(ADDR_STAT_CH0, STAT_USER_MASK);
        cw(ADDR_STAT_CH1, 8'h0b);
        rc(ADDR_STAT_CH1, 8'h00);
        cw(ADDR_STAT_CH0, 8'h00);
        $display("test registers done");
    endtask
    task t_port();
        hdbb_host_model_inst.xfer(1'b0, 1'b0, 1'b0, 8'h99, q);
        repeat (8) @(posedge clk);
        rc(ADDR_STAT_CH0, 8'h00);
        cw(ADDR_CTRL_CH0, 8'h80);
        rc(ADDR_CTRL_CH0, 8'h80);
        hdbb_host_model_inst.xfer(1'b0, 1'b0, 1'b1, 8'ha5, q);
        wt(0, 0, 1);
        rc(ADDR_STAT_CH0, 8'h0a);
        rc(ADDR_DATA_CH0, 8'ha5);
        rc(ADDR_STAT_CH0, 8'h08);
        cw(ADDR_DATA_CH0, 8'h3c);
        rc(ADDR_STAT_CH0, 8'h09);
        hdbb_host_model_inst.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
        chk(q, 8'h09);
        hdbb_host_model_inst.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
        chk(q, 8'h3c);
        wt(1, 0, 1);
        rc(ADDR_STAT_CH0, 8'h08);
        $display("test channel 0 done");
    endtask
    task t_double();
        hdbb_host_model_inst.xfer(1'b1, 1'b0, 1'b0, 8'h11, q);
        repeat (8) @(posedge clk);
        rc(ADDR_STAT_CH1, 8'h00);
        cw(ADDR_CTRL_CH1, 8'h80);
        hdbb_host_model_inst.xfer(1'b1, 1'b0, 1'b0, 8'h5a, q);
        wt(0, 1, 1);
        rc(ADDR_DATA_CH1, 8'h5a);
        cw(ADDR_DATA_CH1, 8'hc3);
        hdbb_host_model_inst.xfer(1'b1, 1'b1, 1'b0, 8'h00, q);
        chk(q, 8'hc3);
        wt(1, 1, 1);
        $display("test double channel done");
    endtask
    task t_rw();
        cw(ADDR_CTRL_CH0, 8'hc0);
        rw_mode = 1'b1;
        hdbb_host_model_inst.idle();
        hdbb_host_model_inst.xfer(1'b0, 1'b0, 1'b0, 8'h77, q);
        wt(0, 0, 2);
        rc(ADDR_DATA_CH0, 8'h77);
        cw(ADDR_DATA_CH0, 8'h42);
        hdbb_host_model_inst.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
        chk(q, 8'h42);
        wt(1, 0, 2);
        cw(ADDR_CTRL_CH0, 8'h80);
        rw_mode = 1'b0;
        hdbb_host_model_inst.idle();
        $display("test direction-line master done");
    endtask
    // One byte in the input buffer, four queued, the sixth refused
    task t_fifo();
        for (int i = 0; i < 6; i++)
            hdbb_host_model_inst.xfer(1'b0, 1'b0, 1'b0, 8'(8'h10 + i), q);
        chk({7'h0, ready}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wt(0, 0, 3 + i);
            rc(ADDR_DATA_CH0, 8'(8'h10 + i));
        end
        repeat (8) @(posedge clk);
        chk({7'h0, ready}, 8'h01);
        rc(ADDR_STAT_CH0, 8'h00);
        $display("test buffer fill and drain done");
    endtask
    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        {wr, rd, rw_mode} = 3'h0;
        addr = 8'h00;
        wdata = 8'h00;
        hdbb_host_model_inst.idle();
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_regs();
        t_port();
        t_double();
        t_rw();
        t_fifo();
        summarize();
    end
endmodule // host_data_bus_buffer_test
`default_nettype wire
